// file: verilog/dcas_top.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module dcas_top #(
  parameter int P_CYC_0P5MS = dcas_pkg::CYC_0P5MS,
  parameter int P_CYC_1MS = dcas_pkg::CYC_1MS,
  parameter int P_CYC_2MS = dcas_pkg::CYC_2MS,
  parameter int P_CYC_4MS = dcas_pkg::CYC_4MS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic startup_req,
  input wire logic [31:0] cal_ring_cnt_in,
  input wire logic [63:0] cal_ierr_in,
  output logic [15:0] div_int,
  output logic [15:0] div_frac,
  output logic div_rst,
  output logic div_resync,
  output logic fast_track,
  output logic [4:0] lpf_coeff,
  output logic int_mode,
  output logic out_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0] accel_q, accel_d;
  logic [7:0] stsel_q, stsel_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] pint_q, pint_d;
  logic [15:0] pfrac_q, pfrac_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] seq_status;
  logic [7:0] ring_sel;
  logic [15:0] ierr_sel;

  function automatic logic [15:0] masked_write(input logic [15:0] old,
                                               input logic [15:0] wval,
                                               input logic [15:0] mask);
    masked_write = (old & ~mask) | (wval & mask);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    ring_sel = cal_ring_cnt_in[8*stsel_q[1:0] +: 8];
    ierr_sel = cal_ierr_in[16*stsel_q[1:0] +: 16];
  end

  always_comb begin
    accel_d = accel_q;
    stsel_d = stsel_q;
    ctrl_d = ctrl_q;
    pint_d = pint_q;
    pfrac_d = pfrac_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      if (hit(reg_addr, dcas_pkg::ADDR_ACCEL)) begin
        accel_d = masked_write(accel_q, reg_wdata, dcas_pkg::ACC_WMASK);
      end
      if (hit(reg_addr, dcas_pkg::ADDR_STSEL)) begin
        stsel_d = (stsel_q & ~dcas_pkg::STSEL_WMASK) |
                  (reg_wdata[7:0] & dcas_pkg::STSEL_WMASK);
      end
      if (hit(reg_addr, dcas_pkg::ADDR_CTRL)) begin
        ctrl_d = masked_write(ctrl_q, reg_wdata, dcas_pkg::CTRL_WMASK);
      end
      if (hit(reg_addr, dcas_pkg::ADDR_PINT)) begin
        pint_d = reg_wdata;
      end
      if (hit(reg_addr, dcas_pkg::ADDR_PFRAC)) begin
        pfrac_d = reg_wdata;
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        dcas_pkg::ADDR_ACCEL: rdata_d = accel_q;
        dcas_pkg::ADDR_STSEL: rdata_d = {8'h00, stsel_q};
        dcas_pkg::ADDR_CTRL: rdata_d = ctrl_q;
        dcas_pkg::ADDR_PINT: rdata_d = pint_q;
        dcas_pkg::ADDR_PFRAC: rdata_d = pfrac_q;
        dcas_pkg::ADDR_SEQST: rdata_d = seq_status;
        dcas_pkg::ADDR_RING: rdata_d = {8'h00, ring_sel};
        dcas_pkg::ADDR_IERR: rdata_d = ierr_sel;
        default: rdata_d = 16'h0000;
      endcase
    end else begin
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accel_q <= dcas_pkg::ACC_RESET;
      stsel_q <= dcas_pkg::STSEL_RESET;
      ctrl_q <= dcas_pkg::CTRL_RESET;
      pint_q <= dcas_pkg::PINT_RESET;
      pfrac_q <= dcas_pkg::PFRAC_RESET;
      rdata_q <= 16'h0000;
    end else if (clk_en) begin
      accel_q <= accel_d;
      stsel_q <= stsel_d;
      ctrl_q <= ctrl_d;
      pint_q <= pint_d;
      pfrac_q <= pfrac_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer and divider value selection

  dcas_tmr_if tif ();

  dcas_interval_timer #(
    .C_0P5MS(P_CYC_0P5MS),
    .C_1MS(P_CYC_1MS),
    .C_2MS(P_CYC_2MS),
    .C_4MS(P_CYC_4MS)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .tif(tif)
  );

  dcas_pkg::dcas_state_t state_q, state_d;
  logic accel_active;
  logic [15:0] sel_int;
  logic [15:0] sel_frac;
  logic sel_fixed;

  dcas_div_select u_sel (
    .active(accel_active),
    .int_sel(accel_q[dcas_pkg::ACC_INT_BIT]),
    .frac_sel(accel_q[dcas_pkg::ACC_FRAC_LSB +: 2]),
    .prog_int(pint_q),
    .prog_frac(pfrac_q),
    .div_int(sel_int),
    .div_frac(sel_frac),
    .fixed_used(sel_fixed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic fod_rst;
  logic fod_rst_prev_q, fod_rst_prev_d;
  logic fixed_seen_q, fixed_seen_d;
  logic [4:0] rs_cnt_q, rs_cnt_d;
  logic tmr_start;
  logic [2:0] tmr_code;

  assign fod_rst = ctrl_q[dcas_pkg::CTRL_FODRST_BIT];
  assign accel_active = (state_q == dcas_pkg::ST_FAST) ||
                        (state_q == dcas_pkg::ST_SETTLE);

  always_comb begin
    state_d = state_q;
    fod_rst_prev_d = fod_rst;
    fixed_seen_d = fixed_seen_q;
    rs_cnt_d = rs_cnt_q;
    tmr_start = 1'b0;
    tmr_code = accel_q[dcas_pkg::ACC_FAST_LSB +: 3];
    if (accel_active && sel_fixed) begin
      fixed_seen_d = 1'b1;
    end
    unique case (state_q)
      dcas_pkg::ST_IDLE: begin
        // Startup with reset low, or a later 1 to 0 edge of the reset bit
        if (!fod_rst && (startup_req || fod_rst_prev_q)) begin
          state_d = dcas_pkg::ST_FAST;
          tmr_start = 1'b1;
          fixed_seen_d = 1'b0;
        end
      end
      dcas_pkg::ST_FAST: begin
        if (tif.expired) begin
          state_d = dcas_pkg::ST_SETTLE;
          tmr_start = 1'b1;
          tmr_code = accel_q[dcas_pkg::ACC_SETTLE_LSB +: 3];
        end
      end
      dcas_pkg::ST_SETTLE: begin
        if (tif.expired) begin
          // Resync only when a fixed value was applied since this sequence started
          if (fixed_seen_q) begin
            state_d = dcas_pkg::ST_RESYNC;
            rs_cnt_d = 5'(dcas_pkg::RESYNC_CYC);
          end else begin
            state_d = dcas_pkg::ST_RUN;
          end
        end
      end
      dcas_pkg::ST_RESYNC: begin
        if (rs_cnt_q <= 5'd1) begin
          state_d = dcas_pkg::ST_RUN;
          rs_cnt_d = 5'd0;
        end else begin
          rs_cnt_d = rs_cnt_q - 5'd1;
        end
      end
      dcas_pkg::ST_RUN: begin
        state_d = dcas_pkg::ST_RUN;
      end
    endcase
    // Setting the reset bit aborts any sequence and drops the outputs
    if (fod_rst) begin
      state_d = dcas_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dcas_pkg::ST_IDLE;
      fod_rst_prev_q <= 1'b0;
      fixed_seen_q <= 1'b0;
      rs_cnt_q <= 5'd0;
    end else if (clk_en) begin
      state_q <= state_d;
      fod_rst_prev_q <= fod_rst_prev_d;
      fixed_seen_q <= fixed_seen_d;
      rs_cnt_q <= rs_cnt_d;
    end
  end

  assign tif.start = tmr_start;
  assign tif.code = tmr_code;

  ////////////////////////////////////////////////////////////////////////////
  // Registered divider outputs

  logic [15:0] dint_q, dint_d;
  logic [15:0] dfrac_q, dfrac_d;
  logic drst_q, drst_d;
  logic rsync_q, rsync_d;
  logic fast_q, fast_d;
  logic [4:0] lpf_q, lpf_d;
  logic imode_q, imode_d;
  logic oen_q, oen_d;
  logic [4:0] lpf_prog;

  assign lpf_prog = ctrl_q[dcas_pkg::CTRL_LPF_LSB +: 5];

  always_comb begin
    dint_d = sel_int;
    dfrac_d = sel_frac;
    drst_d = fod_rst;
    // One pulse when the programmed values are restored
    rsync_d = (state_q == dcas_pkg::ST_SETTLE) && (state_d ==
              dcas_pkg::ST_RESYNC);
    fast_d = (state_d == dcas_pkg::ST_FAST);
    // Out of range coefficients saturate rather than wrap
    lpf_d = (lpf_prog > dcas_pkg::LPF_MAX) ? dcas_pkg::LPF_MAX
                                           : lpf_prog;
    imode_d = ctrl_q[dcas_pkg::CTRL_INTMODE_BIT] &&
              (state_d == dcas_pkg::ST_RUN);
    oen_d = (state_d == dcas_pkg::ST_RUN);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dint_q <= dcas_pkg::PINT_RESET;
      dfrac_q <= dcas_pkg::PFRAC_RESET;
      drst_q <= 1'b1;
      rsync_q <= 1'b0;
      fast_q <= 1'b0;
      lpf_q <= dcas_pkg::LPF_MAX;
      imode_q <= 1'b0;
      oen_q <= 1'b0;
    end else if (clk_en) begin
      dint_q <= dint_d;
      dfrac_q <= dfrac_d;
      drst_q <= drst_d;
      rsync_q <= rsync_d;
      fast_q <= fast_d;
      lpf_q <= lpf_d;
      imode_q <= imode_d;
      oen_q <= oen_d;
    end
  end

  assign seq_status = {8'h00, fixed_seen_q, oen_q, fast_q, 2'b00,
                       state_q};

  assign div_int = dint_q;
  assign div_frac = dfrac_q;
  assign div_rst = drst_q;
  assign div_resync = rsync_q;
  assign fast_track = fast_q;
  assign lpf_coeff = lpf_q;
  assign int_mode = imode_q;
  assign out_en = oen_q;

endmodule

// file: verilog/dcas_pkg.sv
package dcas_pkg;

  // Register offsets (byte addresses, one aligned slot per register)
  localparam logic [7:0] ADDR_ACCEL = 8'h00;
  localparam logic [7:0] ADDR_STSEL = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PINT = 8'h0C;
  localparam logic [7:0] ADDR_PFRAC = 8'h10;
  localparam logic [7:0] ADDR_SEQST = 8'h14;
  localparam logic [7:0] ADDR_RING = 8'h18;
  localparam logic [7:0] ADDR_IERR = 8'h1C;

  // divider_cal_accel_settings fields
  localparam int ACC_INT_BIT = 8;
  localparam int ACC_FRAC_LSB = 6;
  localparam int ACC_FAST_LSB = 3;
  localparam int ACC_SETTLE_LSB = 0;
  localparam logic [15:0] ACC_WMASK = 16'h01FF;
  localparam logic [15:0] ACC_RESET = 16'h0148;

  // cal_status_readback_select
  localparam logic [7:0] STSEL_WMASK = 8'h03;
  localparam logic [7:0] STSEL_RESET = 8'h00;

  // Control register: divider reset, integer mode request, filter coeff
  localparam int CTRL_FODRST_BIT = 0;
  localparam int CTRL_INTMODE_BIT = 1;
  localparam int CTRL_LPF_LSB = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h1F03;
  localparam logic [15:0] CTRL_RESET = 16'h1800;
  localparam logic [4:0] LPF_MAX = 5'h18;

  localparam logic [15:0] PINT_RESET = 16'h0032;
  localparam logic [15:0] PFRAC_RESET = 16'h0000;

  // Fixed divider values used while accelerated calibration runs
  localparam logic [15:0] FIXED_INT = 16'd100;
  localparam logic [15:0] FRAC_QUARTER = 16'h4000;
  localparam logic [15:0] FRAC_HALF = 16'h8000;

  // Timing
  localparam int CLK_MHZ = 125;
  localparam int T_0P5MS_NS = 500000;
  localparam int T_1MS_NS = 1000000;
  localparam int T_2MS_NS = 2000000;
  localparam int T_4MS_NS = 4000000;
  localparam int T_16US_NS = 16000;
  localparam int CYC_0P5MS = T_0P5MS_NS * CLK_MHZ / 1000;
  localparam int CYC_1MS = T_1MS_NS * CLK_MHZ / 1000;
  localparam int CYC_2MS = T_2MS_NS * CLK_MHZ / 1000;
  localparam int CYC_4MS = T_4MS_NS * CLK_MHZ / 1000;
  localparam int CYC_16US = T_16US_NS * CLK_MHZ / 1000;
  localparam int RESYNC_CYC = 16;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {
    IV_SKIP,
    IV_0P5MS,
    IV_1MS,
    IV_2MS,
    IV_4MS,
    IV_RSV5,
    IV_RSV6,
    IV_16US
  } dcas_iv_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FAST,
    ST_SETTLE,
    ST_RESYNC,
    ST_RUN
  } dcas_state_t;

endpackage

// file: verilog/dcas_tmr_if.sv
`timescale 1ns/100ps
interface dcas_tmr_if;
  logic start;
  logic [2:0] code;
  logic expired;

  modport tmr (
    input start,
    input code,
    output expired
  );
  modport ctl (
    output start,
    output code,
    input expired
  );
endinterface

// file: verilog/dcas_interval_timer.sv
`timescale 1ns/100ps
module dcas_interval_timer #(
  parameter int C_0P5MS = dcas_pkg::CYC_0P5MS,
  parameter int C_1MS = dcas_pkg::CYC_1MS,
  parameter int C_2MS = dcas_pkg::CYC_2MS,
  parameter int C_4MS = dcas_pkg::CYC_4MS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  dcas_tmr_if.tmr tif
);

  logic [dcas_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic exp_q, exp_d;

  // Undefined codes load zero so the interval is skipped
  function automatic logic [dcas_pkg::CNT_W-1:0] iv_cycles(
    input logic [2:0] code);
    unique case (dcas_pkg::dcas_iv_t'(code))
      dcas_pkg::IV_0P5MS: iv_cycles = dcas_pkg::CNT_W'(C_0P5MS);
      dcas_pkg::IV_1MS: iv_cycles = dcas_pkg::CNT_W'(C_1MS);
      dcas_pkg::IV_2MS: iv_cycles = dcas_pkg::CNT_W'(C_2MS);
      dcas_pkg::IV_4MS: iv_cycles = dcas_pkg::CNT_W'(C_4MS);
      dcas_pkg::IV_16US: iv_cycles = dcas_pkg::CNT_W'(dcas_pkg::CYC_16US);
      default: iv_cycles = '0;
    endcase
  endfunction

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    exp_d = 1'b0;
    if (tif.start) begin
      cnt_d = iv_cycles(tif.code);
      // A zero length expires at once so a skipped interval lasts one cycle
      busy_d = (iv_cycles(tif.code) != '0);
      exp_d = (iv_cycles(tif.code) == '0);
    end else if (busy_q) begin
      if (cnt_q <= dcas_pkg::CNT_W'(1)) begin
        busy_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - dcas_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      exp_q <= exp_d;
    end
  end

  assign tif.expired = exp_q;

endmodule

// file: verilog/dcas_div_select.sv
`timescale 1ns/100ps
module dcas_div_select (
  input wire logic active,
  input wire logic int_sel,
  input wire logic [1:0] frac_sel,
  input wire logic [15:0] prog_int,
  input wire logic [15:0] prog_frac,
  output logic [15:0] div_int,
  output logic [15:0] div_frac,
  output logic fixed_used
);

  logic int_fixed;
  logic frac_fixed;

  always_comb begin
    int_fixed = active && int_sel;
    frac_fixed = active && (frac_sel == 2'd1 || frac_sel == 2'd2);
    div_int = int_fixed ? dcas_pkg::FIXED_INT : prog_int;
    div_frac = prog_frac;
    if (frac_fixed) begin
      // Code 3 is undefined and keeps the programmed fraction
      div_frac = (frac_sel == 2'd1) ? dcas_pkg::FRAC_QUARTER
                                    : dcas_pkg::FRAC_HALF;
    end
    fixed_used = int_fixed || frac_fixed;
  end

endmodule

// file: testbench/dcas_top_checker.sv
`timescale 1ns/100ps
module dcas_top_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [15:0] div_int,
  input wire logic [15:0] div_frac,
  input wire logic div_rst,
  input wire logic div_resync,
  input wire logic fast_track,
  input wire logic [4:0] lpf_coeff,
  input wire logic int_mode,
  input wire logic out_en
);
  logic [8:0] acc_q;
  logic [8:0] acc_d;

  always_comb begin
    acc_d = acc_q;
    if (clk_en && reg_wr && reg_addr == dcas_pkg::ADDR_ACCEL) begin
      acc_d = reg_wdata[8:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= dcas_pkg::ACC_RESET[8:0];
    end else begin
      acc_q <= acc_d;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Override shows a cycle late, so only settled fast cycles are judged
  sequence s_ovr;
    fast_track && $past(fast_track);
  endsequence

  property p_int_fix;
    s_ovr ##0 acc_q[8] |-> div_int == dcas_pkg::FIXED_INT;
  endproperty
  a_int_fix: assert property (p_int_fix)
    else $error("fixed integer not applied");

  property p_frac_q;
    s_ovr ##0 acc_q[7:6] == 2'd1 |-> div_frac == dcas_pkg::FRAC_QUARTER;
  endproperty
  a_frac_q: assert property (p_frac_q)
    else $error("quarter fraction not applied");

  property p_frac_h;
    s_ovr ##0 acc_q[7:6] == 2'd2 |-> div_frac == dcas_pkg::FRAC_HALF;
  endproperty
  a_frac_h: assert property (p_frac_h)
    else $error("half fraction not held");

  sequence s_resync_gap;
    !out_en [*8];
  endsequence

  property p_resync;
    div_resync |=> s_resync_gap;
  endproperty
  a_resync: assert property (p_resync)
    else $error("outputs enabled during resync");

  property p_out_clean;
    out_en |-> !fast_track && !div_resync;
  endproperty
  a_out_clean: assert property (p_out_clean)
    else $error("outputs enabled inside calibration");

  property p_lpf;
    lpf_coeff <= dcas_pkg::LPF_MAX;
  endproperty
  a_lpf: assert property (p_lpf)
    else $error("filter coefficient above maximum");

  property p_int_mode;
    int_mode |-> out_en || $past(out_en);
  endproperty
  a_int_mode: assert property (p_int_mode)
    else $error("integer mode before calibration end");

  property p_rst_idle;
    div_rst |=> !out_en;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs enabled while divider held in reset");
endmodule

bind dcas_top dcas_top_checker u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .div_int(div_int),
  .div_frac(div_frac),
  .div_rst(div_rst),
  .div_resync(div_resync),
  .fast_track(fast_track),
  .lpf_coeff(lpf_coeff),
  .int_mode(int_mode),
  .out_en(out_en)
);

// file: testbench/dcas_div_model.sv
`timescale 1ns/100ps
module dcas_div_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic div_resync,
  output logic [31:0] cal_ring_cnt_in,
  output logic [63:0] cal_ierr_in,
  output int n_resync
);
  // Distinct status per index so a wrong readback selection shows
  assign cal_ring_cnt_in = 32'hD4C3_B2A1;
  assign cal_ierr_in = 64'h5A03_5A02_5A01_5A00;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_resync <= 0;
    end else if (div_resync === 1'b1) begin
      n_resync <= n_resync + 1;
    end
  end
endmodule

// file: testbench/dcas_top_bench.sv
`timescale 1ns/100ps
module dcas_top_bench;
  typedef struct {
    logic [15:0] acc;
    logic [15:0] i;
    logic [15:0] f;
    int rs;
    int len;
  } dcas_row_t;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic startup_req = 1'b0;
  logic [15:0] reg_rdata;
  logic [31:0] ring;
  logic [63:0] ierr;
  logic [15:0] div_int;
  logic [15:0] div_frac;
  logic div_rst;
  logic div_resync;
  logic fast_track;
  logic [4:0] lpf_coeff;
  logic int_mode;
  logic out_en;
  int n_resync;
  int miscompares = 0;
  int n_compared = 0;
  // Fast lengths are N+1 cycles with the shortened interval counts
  dcas_row_t rows [7] = '{
    '{16'h0148, 16'h0064, 16'h4000, 1, 21},
    '{16'h0089, 16'h0040, 16'h8000, 1, 21},
    '{16'h0012, 16'h0040, 16'h1234, 0, 31},
    '{16'h00DB, 16'h0040, 16'h1234, 0, 41},
    '{16'h0124, 16'h0064, 16'h1234, 1, 51},
    '{16'h002E, 16'h0040, 16'h1234, 0, 1},
    '{16'h0038, 16'h0040, 16'h1234, 0, 2001}
  };

  always #4 clk_sys = ~clk_sys;

  dcas_top #(.P_CYC_0P5MS(20), .P_CYC_1MS(30), .P_CYC_2MS(40),
    .P_CYC_4MS(50)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .startup_req(startup_req),
    .cal_ring_cnt_in(ring), .cal_ierr_in(ierr), .div_int(div_int),
    .div_frac(div_frac), .div_rst(div_rst), .div_resync(div_resync),
    .fast_track(fast_track), .lpf_coeff(lpf_coeff),
    .int_mode(int_mode), .out_en(out_en));

  dcas_div_model u_div (.clk_sys(clk_sys), .rst_n(rst_n),
    .div_resync(div_resync), .cal_ring_cnt_in(ring),
    .cal_ierr_in(ierr), .n_resync(n_resync));

  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      miscompares++;
      $display("wrong value at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk16(reg_rdata, exp);
  endtask

  task automatic run_row(input dcas_row_t r, input bit first,
    input logic [15:0] c);
    int cnt;
    int rs0;
    wr(dcas_pkg::ADDR_ACCEL, r.acc);
    rs0 = n_resync;
    if (first) begin
      @(posedge clk_sys);
      startup_req <= 1'b1;
      @(posedge clk_sys);
      startup_req <= 1'b0;
    end else begin
      wr(dcas_pkg::ADDR_CTRL, 16'h1801);
      repeat (3) @(posedge clk_sys);
      wr(dcas_pkg::ADDR_CTRL, c);
    end
    cnt = 0;
    #1;
    while (fast_track !== 1'b1 && cnt < 10) begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    cnt = 0;
    while (fast_track === 1'b1 && cnt < 3000) begin
      @(posedge clk_sys);
      #1 cnt++;
      if (cnt == 1) begin
        chk16(div_int, r.i);
        chk16(div_frac, r.f);
      end
    end
    chkn(cnt, r.len);
    cnt = 0;
    while (out_en !== 1'b1 && cnt < 200) begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    chk16(16'(out_en), 16'h0001);
    chkn(n_resync - rs0, r.rs);
    chk16(div_int, 16'h0040);
    chk16(div_frac, 16'h1234);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(dcas_pkg::ADDR_PINT, 16'h0040);
    wr(dcas_pkg::ADDR_PFRAC, 16'h1234);
    for (int k = 0; k < 7; k++) begin
      run_row(rows[k], k == 0, 16'h1800);
    end
    // Integer mode requested together with the restart
    run_row('{16'h0009, 16'h0040, 16'h1234, 0, 21}, 1'b0, 16'h1802);
    repeat (2) @(posedge clk_sys);
    #1 chk16(16'(int_mode), 16'h0001);
    rchk(dcas_pkg::ADDR_SEQST, 16'h0044);
    wr(dcas_pkg::ADDR_CTRL, 16'hFFFF);
    rchk(dcas_pkg::ADDR_CTRL, 16'h1F03);
    #1 chk16(16'(lpf_coeff), 16'h0018);
    wr(dcas_pkg::ADDR_CTRL, 16'h0501);
    repeat (2) @(posedge clk_sys);
    #1 chk16(16'(lpf_coeff), 16'h0005);
    chk16(16'(out_en), 16'h0000);
    wr(dcas_pkg::ADDR_ACCEL, 16'hFFFF);
    rchk(dcas_pkg::ADDR_ACCEL, 16'h01FF);
    for (int n = 0; n < 4; n++) begin
      wr(dcas_pkg::ADDR_STSEL, 16'hFFFC | 16'(n));
      rchk(dcas_pkg::ADDR_STSEL, 16'(n));
      rchk(dcas_pkg::ADDR_RING, {8'h00, 8'(8'hA1 + 8'h11 * n)});
      rchk(dcas_pkg::ADDR_IERR, 16'h5A00 + 16'(n));
    end
    rchk(8'h20, 16'h0000);
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(dcas_pkg::ADDR_PINT, 16'h7777);
    clk_en <= 1'b1;
    rchk(dcas_pkg::ADDR_PINT, 16'h0040);
    // Reset in mid-calibration must drop back to the idle defaults
    wr(dcas_pkg::ADDR_CTRL, 16'h1800);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b0;
    #1 chk16(div_int, 16'h0032);
    chk16(16'({fast_track, out_en, div_rst}), 16'h0001);
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(dcas_pkg::ADDR_ACCEL, 16'h0148);
    rchk(dcas_pkg::ADDR_STSEL, 16'h0000);
    rchk(dcas_pkg::ADDR_CTRL, 16'h1800);
    final_report();
  end
endmodule
